// file: hdl/rip_pkg.sv
`include "rip_regs.svh"

package rip_pkg;

  typedef logic [`RIP_NUM_REGS-1:0] rip_word_t;

  // levels seen on the device pins
  typedef struct packed {
    logic      preload_hv;
    logic      dev_clk;
    rip_word_t io_level;
  } rip_pins_s;

  typedef enum logic [0:0] {
    RIP_CLEARING,
    RIP_RUNNING
  } rip_state_e;

endpackage

// file: hdl/rip_preload.sv
`timescale 1ns/1ps
`include "rip_regs.svh"

module rip_preload
  import rip_pkg::*;
(
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  // device pins
  input  wire rip_pins_s pins,
  // logic array and polarity configuration
  input  wire rip_word_t array_next,
  input  wire rip_word_t output_polarity_select,
  // register state and pin levels
  output rip_word_t      reg_q,
  output rip_word_t      pin_level,
  output logic           preload_active,
  output logic           clear_busy
);

  rip_pins_s                 pins_meta;
  rip_pins_s                 pins_sync;
  logic                      dev_clk_prev;
  rip_state_e                state;
  rip_state_e                next_state;
  logic [`RIP_TPR_CNT_W-1:0] tpr_cnt;
  logic [`RIP_TPR_CNT_W-1:0] next_tpr_cnt;
  rip_word_t                 next_reg;

  // synchronised pin views
  wire logic      dev_clk_level;
  wire logic      preload_level;
  wire rip_word_t io_level_sync;

  // decodes of the interval state and the clock pin
  wire logic      clearing_now;
  wire logic      clearing_next;
  wire logic      running_now;
  wire logic      dev_clk_edge;
  wire logic      dev_clk_rise;
  wire logic      tpr_done;

  // load selection and next output values
  wire logic      in_preload;
  wire logic      do_preload;
  wire logic      do_normal;
  wire rip_word_t next_pin_level;
  wire logic      next_preload_active;
  wire logic      next_clear_busy;

  // true while the power-up reset interval is still running
  function automatic logic rip_is_clearing(input rip_state_e s);
    return (s == RIP_CLEARING);
  endfunction

  // rising edge of a synchronised level against its delayed copy
  function automatic logic rip_rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // one register bit: clear wins, then pin preload, then array load, else hold
  function automatic logic rip_next_bit(
    input logic clr,
    input logic from_pin,
    input logic from_array,
    input logic pin_bit,
    input logic array_bit,
    input logic cur_bit
  );
    logic nb;
    nb = cur_bit;
    if (clr) begin
      nb = 1'b0;
    end else if (from_pin) begin
      nb = pin_bit;
    end else if (from_array) begin
      nb = array_bit;
    end
    return nb;
  endfunction

  // first synchroniser stage, read by nothing but the second
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pins_meta <= '0;
    end else begin
      pins_meta <= pins;
    end
  end

  // second stage, the only pin view the logic reads
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pins_sync <= '0;
    end else begin
      pins_sync <= pins_meta;
    end
  end

  // named fields of the second stage
  assign dev_clk_level = pins_sync.dev_clk;
  assign preload_level = pins_sync.preload_hv;
  assign io_level_sync = pins_sync.io_level;

  // low after reset, like the idle pin, so no false rise follows reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dev_clk_prev <= 1'b0;
    end else begin
      dev_clk_prev <= dev_clk_level;
    end
  end

  // state decodes shared by edge gating, registers and busy flag
  assign clearing_now  = rip_is_clearing(state);
  assign clearing_next = rip_is_clearing(next_state);
  assign running_now   = ~clearing_now;
  assign dev_clk_edge  = rip_rose(dev_clk_level, dev_clk_prev);

  // clock edges inside the interval are ignored
  assign dev_clk_rise = dev_clk_edge & running_now;
  // worst-case interval, so a slow supply still gets its full clear
  assign tpr_done     = (tpr_cnt == `RIP_TPR_CNT_W'(`RIP_TPR_CYCLES - 1));

  // preload mode while high voltage present
  assign in_preload = preload_level;
  // clock pulse in preload loads pins
  assign do_preload = dev_clk_rise & in_preload;
  // normal edge reloads from the array
  assign do_normal  = dev_clk_rise & ~in_preload;

  // power-up reset interval sequencing
  always_comb begin
    next_state   = state;
    next_tpr_cnt = tpr_cnt;
    unique case (state)
      RIP_CLEARING: begin
        next_tpr_cnt = tpr_cnt + `RIP_TPR_CNT_W'(1);
        if (tpr_done) begin
          next_state = RIP_RUNNING;
        end
      end
      RIP_RUNNING: begin
        next_tpr_cnt = '0;
      end
    endcase
  end

  // interval state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= RIP_CLEARING;
    end else begin
      state <= next_state;
    end
  end

  // interval counter, idle at zero from the second running cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tpr_cnt <= '0;
    end else begin
      tpr_cnt <= next_tpr_cnt;
    end
  end

  // per-register next value
  generate
    for (genvar i = 0; i < `RIP_NUM_REGS; i++) begin : g_reg
      // each bit loaded on its own
      assign next_reg[i] = rip_next_bit(clearing_now, do_preload, do_normal,
                                        io_level_sync[i], array_next[i], reg_q[i]);
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_q <= `RIP_REG_RESET;
    end else begin
      reg_q <= next_reg;
    end
  end

  assign next_pin_level = next_reg ^ output_polarity_select;

  // pin levels move in the same cycle as the registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_level <= `RIP_REG_RESET;
    end else begin
      pin_level <= next_pin_level;
    end
  end

  // flag follows the synchronised preload pin
  assign next_preload_active = in_preload;
  assign next_clear_busy     = clearing_next;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      preload_active <= 1'b0;
    end else begin
      preload_active <= next_preload_active;
    end
  end

  // busy for the whole power-up reset interval
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clear_busy <= 1'b1;
    end else begin
      clear_busy <= next_clear_busy;
    end
  end

endmodule

// file: hdl/rip_regs.svh
// Notes on behaviour
// - after power-up every register clears low without any device clock edge.
// - after the clear each pin shows the cleared value through its polarity select.
// - high voltage on the preload pin puts the device in preload mode.
// - in preload a clock pulse copies every I/O pin level into all ten registers.
// - preload loads the pin level directly, ignoring the polarity select.
// - each register loads high or low independently, any combination allowed.
`ifndef RIP_REGS_SVH
`define RIP_REGS_SVH

`define RIP_NUM_REGS        10
`define RIP_REG_RESET       10'h000
`define RIP_CLK_PERIOD_NS   10
`define RIP_TPR_TYP_NS      600
`define RIP_TPR_MAX_NS      1000
`define RIP_TPR_CYCLES      (`RIP_TPR_MAX_NS / `RIP_CLK_PERIOD_NS)
`define RIP_TPR_CNT_W       7

`endif

// file: verification/rip_chk.sv
`timescale 1ns/1ps
module rip_chk
  import rip_pkg::*;
(
  // watched ports
  input wire logic      ref_clk,
  input wire logic      rst_n,
  input wire rip_pins_s pins,
  input wire rip_word_t array_next,
  input wire rip_word_t output_polarity_select,
  input wire rip_word_t reg_q,
  input wire rip_word_t pin_level,
  input wire logic      preload_active,
  input wire logic      clear_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_CLR: assert property (clear_busy |-> reg_q == 10'h000)
    else $error("reg not clear");
  AST_LEN: assert property ($rose(rst_n) |-> ##99 clear_busy ##1 !clear_busy)
    else $error("clear length");
  AST_POL: assert property ($past(rst_n) |-> pin_level == (reg_q ^ $past(output_polarity_select)))
    else $error("pin level");
  AST_ACT: assert property ($past(rst_n, 3) |-> preload_active == $past(pins.preload_hv, 3))
    else $error("preload flag");
  AST_PRE: assert property ($past(pins.dev_clk) && !$past(pins.dev_clk, 2)
    && $past(pins.preload_hv) && !clear_busy |-> ##2 reg_q == $past(pins.io_level, 3))
    else $error("preload load");
  AST_NRM: assert property ($past(pins.dev_clk) && !$past(pins.dev_clk, 2)
    && !$past(pins.preload_hv) && !clear_busy |-> ##2 reg_q == $past(array_next))
    else $error("normal load");
  AST_HOLD: assert property ($changed(reg_q) |-> $past(pins.dev_clk, 3) && !$past(pins.dev_clk, 4))
    else $error("reg changed");
endmodule
bind rip_preload rip_chk u_chk (.ref_clk, .rst_n, .pins, .array_next,
  .output_polarity_select, .reg_q, .pin_level, .preload_active, .clear_busy);

// file: verification/rip_pin_drv.sv
`timescale 1ns/1ps
module rip_pin_drv
  import rip_pkg::*;
(
  // clock and pins
  input wire logic ref_clk,
  output rip_pins_s pins
);
  initial pins = '0;
  task automatic pulse(input logic hv, input rip_word_t d);
    pins.preload_hv <= hv;
    pins.io_level <= d;
    repeat (4) @(posedge ref_clk);
    pins.dev_clk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pins.dev_clk <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pins.io_level <= ~d;
    @(posedge ref_clk);
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb
  import rip_pkg::*;
;
  logic      ref_clk = 1'b0;
  logic      rst_n = 1'b0;
  rip_pins_s pins;
  rip_word_t arr = 10'h000, pol = 10'h000, q, pl;
  logic      act, busy;
  int        n_mismatch = 0, cmp_count = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  rip_pin_drv u_drv (.ref_clk, .pins);
  rip_preload u_dut (.ref_clk, .rst_n, .pins, .array_next(arr),
    .output_polarity_select(pol), .reg_q(q), .pin_level(pl),
    .preload_active(act), .clear_busy(busy));
  function automatic rip_word_t want(logic hv, rip_word_t d, rip_word_t a);
    return hv ? d : a;
  endfunction
  task automatic chk(input string nm, input rip_word_t e, input rip_word_t s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    logic hv;
    rip_word_t d;
    void'($urandom(16));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    pol <= 10'($urandom);
    repeat (50) @(posedge ref_clk);
    chk("busy", 10'h001, {9'h000, busy});
    repeat (60) @(posedge ref_clk);
    chk("busy", 10'h000, {9'h000, busy});
    chk("reg", 10'h000, q);
    chk("pin", pol, pl);
    for (int i = 0; i < 24; i++) begin
      hv = i < 2 ? 1'b1 : 1'($urandom);
      d = i == 0 ? 10'h000 : i == 1 ? 10'h3ff : 10'($urandom);
      arr <= 10'($urandom);
      pol <= 10'($urandom);
      u_drv.pulse(hv, d);
      chk("reg", want(hv, d, arr), q);
      chk("pin", want(hv, d, arr) ^ pol, pl);
      chk("act", {9'h000, hv}, {9'h000, act});
    end
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (50) @(posedge ref_clk);
    chk("reg", 10'h000, q);
    chk("busy", 10'h001, {9'h000, busy});
    chk("pin", pol, pl);
    repeat (60) @(posedge ref_clk);
    u_drv.pulse(1'b1, 10'h155);
    chk("reg", 10'h155, q);
    final_report();
  end
endmodule
